/* File: core/spe_pkg.sv */
// spe_pkg: constants and types for the serial programming entry block.
// assumes: nothing; imported whole by every design file of the block.
package spe_pkg;

   // -------------------------------------------------------------
   // key shifter sizing
   // -------------------------------------------------------------
   localparam int          KEY_W       = 32;           // key length in bits
   localparam int          CNT_W       = 6;            // bit counter width
   localparam logic [5:0]  CNT_FULL    = 6'h20;        // 32 bits collected
   localparam logic [5:0]  CNT_LAST    = 6'h1f;        // index of last key bit
   localparam logic [5:0]  CNT_RST     = 6'h00;
   localparam logic [31:0] KEY_DEFAULT = 32'h5a3c_96e1; // arbitrary value
   localparam logic [31:0] SHIFT_RST   = 32'h0000_0000;

   // -------------------------------------------------------------
   // synchroniser bit positions (clock domain)
   // -------------------------------------------------------------
   localparam int          SYNC_W      = 5;
   localparam int          SY_MASTER_CLEAR_PIN     = 0;            // master clear pin high
   localparam int          SY_VPP      = 1;            // high programming level seen
   localparam int          SY_SCLK     = 2;            // serial clock level
   localparam int          SY_SDAT     = 3;            // serial data level
   localparam int          SY_MATCH    = 4;            // key accepted (link domain)
   localparam logic [4:0]  SYNC_RST    = 5'h00;

   // -------------------------------------------------------------
   // session states and carriers
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_HV   = 3'b010,
      ST_LV   = 3'b100
   } spe_state_t;

   typedef struct packed {
      logic mode;    // program/verify active
      logic hv;      // high-voltage session
      logic lv;      // low-voltage session
   } spe_session_t;

   typedef struct packed {
      logic lvp_enable;      // low_voltage_prog_enable configuration bit
      logic master_clear_pin_reset_cfg;  // master-clear reset enable from configuration
   } spe_config_t;

   localparam spe_session_t SESSION_RST = 3'h0;

endpackage

/* File: core/spe_key_shift.sv */
// spe_key_shift: collects the entry key on the programmer's serial clock.
// assumes: clear_async rises whenever master clear is released or rst is high.
`timescale 1ns/1ps
module spe_key_shift
   import spe_pkg::*;
#(
   parameter logic [KEY_W-1:0] KEY         = KEY_DEFAULT,
   parameter bit               MSB_FIRST   = 1'b1,
   parameter bit               SAMPLE_RISE = 1'b1
) (
   input  wire logic prog_serial_clock,
   input  wire logic clear_async,
   input  wire logic prog_serial_data_in,
   output logic      key_match
);

   // -------------------------------------------------------------
   // sampling edge and state
   // -------------------------------------------------------------
   logic             sample_clk;
   logic [KEY_W-1:0] shift_reg;
   logic [KEY_W-1:0] shift_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             match_reg;
   logic             match_next;

   // pick the sampling edge of the link clock
   assign sample_clk = SAMPLE_RISE ? prog_serial_clock : ~prog_serial_clock;
   assign key_match  = match_reg;

   // next shift, count and match; only the first 32 bits count
   always_comb begin
      shift_next = shift_reg;
      cnt_next   = cnt_reg;
      match_next = match_reg;
      if (cnt_reg != CNT_FULL) begin
         if (MSB_FIRST) begin
            shift_next = {shift_reg[KEY_W-2:0], prog_serial_data_in};
         end else begin
            shift_next = {prog_serial_data_in, shift_reg[KEY_W-1:1]};
         end
         cnt_next = cnt_reg + 6'h01;
         if (cnt_reg == CNT_LAST && shift_next == KEY) begin
            match_next = 1'b1;
         end
      end
   end

   // registers; cleared by the frame's own end (master clear released)
   always_ff @(posedge sample_clk or posedge clear_async) begin
      if (clear_async) begin
         shift_reg <= SHIFT_RST;
         cnt_reg   <= CNT_RST;
         match_reg <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         cnt_reg   <= cnt_next;
         match_reg <= match_next;
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   AST_MATCH_AFTER_FULL_KEY: assert property (
      @(posedge sample_clk) disable iff (clear_async)
      match_reg |-> cnt_reg == CNT_FULL)
      else $error("key match without 32 collected bits");

endmodule

/* File: core/spe_entry.sv */
// spe_entry: program/verify mode entry and session control.
// assumes: pins arrive unsynchronised; config bits and resp_* are on clock;
//          the serial command engine itself sits outside this block.
`timescale 1ns/1ps

module spe_entry
   import spe_pkg::*;
#(
   parameter logic [KEY_W-1:0] KEY         = KEY_DEFAULT,
   parameter bit               MSB_FIRST   = 1'b1,
   parameter bit               SAMPLE_RISE = 1'b1
) (
   input  wire logic   clock,
   input  wire logic   rst,
   input  wire logic   prog_serial_clock,
   input  wire logic   prog_serial_data_in,
   input  wire logic   master_clear_vpp_in,
   input  wire logic   high_programming_level_in,
   input  spe_config_t cfg,
   input  wire logic   resp_bit,
   input  wire logic   resp_drive,
   output logic        prog_serial_data_out,
   output logic        prog_serial_data_oe_n,
   output spe_session_t session,
   output logic        master_clear_pin_reset_enable,
   output logic        lvp_clear_allow,
   output logic        rx_clock_level,
   output logic        rx_data_level
);

   // -------------------------------------------------------------
   // elaboration checks
   // -------------------------------------------------------------
   if (KEY_W != 32) begin : g_key_check
      $error("key width must be 32");
   end

   // -------------------------------------------------------------
   // link domain: key collection
   // -------------------------------------------------------------
   logic link_clear;
   logic key_match_link;

   // released master clear or reset ends the key frame
   assign link_clear = rst | master_clear_vpp_in;

   spe_key_shift #(
      .KEY         (KEY),
      .MSB_FIRST   (MSB_FIRST),
      .SAMPLE_RISE (SAMPLE_RISE)
   ) u_key_shift (
      .prog_serial_clock   (prog_serial_clock),
      .clear_async         (link_clear),
      .prog_serial_data_in (prog_serial_data_in),
      .key_match           (key_match_link)
   );

   // -------------------------------------------------------------
   // synchronisers into the clock domain
   // -------------------------------------------------------------
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic [SYNC_W-1:0] sync_next;
   logic              vpp_prev_reg;
   logic              vpp_prev_next;

   // gather asynchronous levels for the first stage
   always_comb begin
      sync_next           = SYNC_RST;
      sync_next[SY_MASTER_CLEAR_PIN]  = master_clear_vpp_in;
      sync_next[SY_VPP]   = high_programming_level_in;
      sync_next[SY_SCLK]  = prog_serial_clock;
      sync_next[SY_SDAT]  = prog_serial_data_in;
      sync_next[SY_MATCH] = key_match_link;
      vpp_prev_next       = sync2_reg[SY_VPP];
   end

   // two flops; only the second stage is read by logic
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_reg    <= SYNC_RST;
         sync2_reg    <= SYNC_RST;
         vpp_prev_reg <= 1'b0;
      end else begin
         sync1_reg    <= sync_next;
         sync2_reg    <= sync1_reg;
         vpp_prev_reg <= vpp_prev_next;
      end
   end

   logic master_clear_pin_s;
   logic vpp_s;
   logic sclk_s;
   logic sdat_s;
   logic match_s;
   logic vpp_rise;

   assign master_clear_pin_s   = sync2_reg[SY_MASTER_CLEAR_PIN];
   assign vpp_s    = sync2_reg[SY_VPP];
   assign sclk_s   = sync2_reg[SY_SCLK];
   assign sdat_s   = sync2_reg[SY_SDAT];
   assign match_s  = sync2_reg[SY_MATCH];
   assign vpp_rise = vpp_s & ~vpp_prev_reg;

   // -------------------------------------------------------------
   // session state machine
   // -------------------------------------------------------------
   spe_state_t state_reg;
   spe_state_t state_next;
   logic       hv_entry;
   logic       lv_entry;

   // entry conditions
   assign hv_entry = vpp_rise & ~sclk_s & ~sdat_s;
   assign lv_entry = cfg.lvp_enable & match_s & ~master_clear_pin_s & ~vpp_s;

   // next session state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (hv_entry) begin
               state_next = ST_HV;
            end else if (lv_entry) begin
               state_next = ST_LV;
            end
         end
         ST_HV: begin
            if (!vpp_s) begin
               state_next = ST_IDLE;
            end
         end
         ST_LV: begin
            if (master_clear_pin_s) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   spe_session_t session_reg;
   spe_session_t session_next;
   logic         master_clear_pin_en_reg;
   logic         master_clear_pin_en_next;
   logic         lvp_clr_reg;
   logic         lvp_clr_next;
   logic         dat_out_reg;
   logic         dat_out_next;
   logic         oe_n_reg;
   logic         oe_n_next;
   logic         rx_clk_reg;
   logic         rx_clk_next;
   logic         rx_dat_reg;
   logic         rx_dat_next;

   // output values from the current state, config bits, resp_* and synchronised pin levels
   always_comb begin
      session_next.hv   = (state_reg == ST_HV);
      session_next.lv   = (state_reg == ST_LV);
      session_next.mode = (state_reg != ST_IDLE);
      master_clear_pin_en_next      = cfg.lvp_enable | cfg.master_clear_pin_reset_cfg;
      lvp_clr_next      = (state_reg == ST_HV);
      dat_out_next      = resp_bit;
      oe_n_next         = ~((state_reg != ST_IDLE) & resp_drive);
      rx_clk_next       = (state_reg != ST_IDLE) & sclk_s;
      rx_dat_next       = (state_reg != ST_IDLE) & sdat_s;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         session_reg <= SESSION_RST;
         master_clear_pin_en_reg <= 1'b0;
         lvp_clr_reg <= 1'b0;
         dat_out_reg <= 1'b0;
         oe_n_reg    <= 1'b1;
         rx_clk_reg  <= 1'b0;
         rx_dat_reg  <= 1'b0;
      end else begin
         session_reg <= session_next;
         master_clear_pin_en_reg <= master_clear_pin_en_next;
         lvp_clr_reg <= lvp_clr_next;
         dat_out_reg <= dat_out_next;
         oe_n_reg    <= oe_n_next;
         rx_clk_reg  <= rx_clk_next;
         rx_dat_reg  <= rx_dat_next;
      end
   end

   assign session               = session_reg;
   assign master_clear_pin_reset_enable     = master_clear_pin_en_reg;
   assign lvp_clear_allow       = lvp_clr_reg;
   assign prog_serial_data_out  = dat_out_reg;
   assign prog_serial_data_oe_n = oe_n_reg;
   assign rx_clock_level        = rx_clk_reg;
   assign rx_data_level         = rx_dat_reg;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_HV_ENTRY: assert property (
      state_reg == ST_IDLE && vpp_rise && !sclk_s && !sdat_s |=> state_reg == ST_HV ##1
      session_reg.hv && session_reg.mode)
      else $error("high-voltage entry not taken");
   AST_HV_EXIT: assert property (
      state_reg == ST_HV && !vpp_s |=> state_reg == ST_IDLE)
      else $error("high-voltage session outlived the level");
   AST_LV_ENTRY: assert property (
      state_reg == ST_IDLE && !vpp_rise && cfg.lvp_enable && match_s && !master_clear_pin_s && !vpp_s
      |=> state_reg == ST_LV ##1 session_reg.lv)
      else $error("low-voltage entry not taken");
   AST_LV_BLOCKED: assert property (
      state_reg != ST_LV && !cfg.lvp_enable |=> state_reg != ST_LV)
      else $error("low-voltage entry with enable clear");
   AST_LV_NEEDS_KEY: assert property (
      state_reg == ST_IDLE && !match_s |=> state_reg != ST_LV)
      else $error("low-voltage entry without key");
   AST_LV_EXIT: assert property (
      state_reg == ST_LV && master_clear_pin_s |=> state_reg == ST_IDLE ##1 !session_reg.mode)
      else $error("low-voltage session kept after release");
   AST_MASTER_CLEAR_PIN_FORCED: assert property (
      cfg.lvp_enable |=> master_clear_pin_reset_enable)
      else $error("master-clear reset not forced on");
   AST_LVP_CLEAR_HV_ONLY: assert property (
      lvp_clear_allow |-> $past(state_reg) == ST_HV)
      else $error("enable clear allowed outside high-voltage");
   AST_DRIVE_IN_MODE: assert property (
      !prog_serial_data_oe_n |-> $past(state_reg) != ST_IDLE && $past(resp_drive))
      else $error("data pin driven outside program mode");
   AST_RX_GATED: assert property (
      !session_reg.mode |-> !rx_clock_level && !rx_data_level)
      else $error("serial levels passed outside program mode");

   COV_HV_SESSION: cover property (state_reg == ST_IDLE ##1 state_reg == ST_HV);
   COV_LV_SESSION: cover property (state_reg == ST_IDLE ##1 state_reg == ST_LV);
   COV_LV_RELEASE: cover property (state_reg == ST_LV ##1 state_reg == ST_IDLE);
   COV_DRIVE:      cover property (!prog_serial_data_oe_n);

endmodule

/* File: dv/spe_prog_model.sv */
// spe_prog_model: behavioural programmer driving the serial programming pins.
// assumes: tb_top calls its tasks and resolves the data pin with the device side.
`timescale 1ns/1ps
module spe_prog_model
   import spe_pkg::*;
(
   output logic prog_serial_clock,
   output logic data_drive,
   output logic master_clear_vpp,
   output logic high_level
);

   logic drive_en;
   logic drive_val;

   // --------------------------------------------------------
   // pin drive
   // --------------------------------------------------------
   // a released line shows the inverse of the last driven value
   assign data_drive = drive_en ? drive_val : ~drive_val;

   initial begin
      prog_serial_clock = 1'b0;
      drive_en          = 1'b1;
      drive_val         = 1'b0;
      master_clear_vpp  = 1'b1;
      high_level        = 1'b0;
   end

   // clock held low and data set to dat, then high level raised
   task automatic hv_enter(input logic dat);
      #1.7;                                  // step off the system clock edges
      drive_en          = 1'b1;
      drive_val         = dat;
      prog_serial_clock = 1'b0;
      #100;
      high_level        = 1'b1;
   endtask

   task automatic hv_exit();
      #1.7;
      high_level = 1'b0;
      #100;
   endtask

   task automatic set_data(input logic v);
      drive_en  = 1'b1;
      drive_val = v;
   endtask

   // static clock level, used only inside a session
   task automatic set_clock(input logic v);
      prog_serial_clock = v;
   endtask

   // master clear low, then key shifted msb first on rising clock
   task automatic send_key(input logic [KEY_W-1:0] k);
      #1.7;                                  // link edges never meet clock edges
      master_clear_vpp = 1'b0;
      #50;
      drive_en = 1'b1;
      for (int i = KEY_W - 1; i >= 0; i--) begin
         drive_val         = k[i];
         #6;
         prog_serial_clock = 1'b1;
         #6;
         prog_serial_clock = 1'b0;
      end
      drive_en = 1'b0;                       // clock stands low after the frame
   endtask

   // releasing master clear ends the low-voltage session
   task automatic master_clear_pin_release();
      #1.7;
      master_clear_vpp = 1'b1;
      #50;
   endtask

endmodule

/* File: dv/tb_top.sv */
// tb_top: self-checking bench for spe_entry with a programmer model.
// assumes: spe_pkg compiled first; spe_prog_model is the far side.
`timescale 1ns/1ps
module tb_top
   import spe_pkg::*;
;

   logic         clock;
   logic         rst;
   spe_config_t  cfg;
   logic         resp_bit;
   logic         resp_drive;
   wire          sclk;
   wire          pm_dat;
   wire          master_clear_pin;
   wire          hvl;
   logic         data_pin;
   logic         dout;
   logic         oe_n;
   spe_session_t session;
   logic         master_clear_pin_en;
   logic         clr_allow;
   logic         rx_clk;
   logic         rx_dat;
   int           n_fail;
   int           n_compared;

   // device drives the pin while its enable is low, else the programmer
   assign data_pin = (oe_n === 1'b0) ? dout : pm_dat;

   spe_entry #(.KEY(KEY_DEFAULT), .MSB_FIRST(1'b1), .SAMPLE_RISE(1'b1)) i_dut (
      .clock                    (clock),
      .rst                      (rst),
      .prog_serial_clock        (sclk),
      .prog_serial_data_in      (data_pin),
      .master_clear_vpp_in      (master_clear_pin),
      .high_programming_level_in(hvl),
      .cfg                      (cfg),
      .resp_bit                 (resp_bit),
      .resp_drive               (resp_drive),
      .prog_serial_data_out     (dout),
      .prog_serial_data_oe_n    (oe_n),
      .session                  (session),
      .master_clear_pin_reset_enable        (master_clear_pin_en),
      .lvp_clear_allow          (clr_allow),
      .rx_clock_level           (rx_clk),
      .rx_data_level            (rx_dat)
   );

   spe_prog_model i_prog (
      .prog_serial_clock(sclk),
      .data_drive       (pm_dat),
      .master_clear_vpp (master_clear_pin),
      .high_level       (hvl)
   );

   // --------------------------------------------------------
   // helpers
   // --------------------------------------------------------
   always #10 clock = ~clock;

   task automatic chk(input logic [7:0] act, input logic [7:0] exp);
      n_compared++;
      if (act !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, act, exp);
      end
   endtask

   task automatic set_in(input logic [1:0] c, input logic drv, input logic bt);
      @(posedge clock);
      cfg        <= spe_config_t'(c);
      resp_drive <= drv;
      resp_bit   <= bt;
   endtask

   // bounded wait for a session value, then compare
   task automatic wait_sess(input logic [2:0] exp);
      for (int i = 0; i < 12 && session !== spe_session_t'(exp); i++) begin
         @(posedge clock);
         #1;
      end
      chk({5'h00, session}, {5'h00, exp});
   endtask

   task automatic lv_try(input logic [1:0] c, input logic [KEY_W-1:0] k, input logic [2:0] e);
      set_in(c, 1'b0, 1'b0);
      i_prog.send_key(k);
      repeat (8) @(posedge clock);         // let a refused key show nothing
      #1;
      wait_sess(e);
   endtask

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // --------------------------------------------------------
   // scenarios
   // --------------------------------------------------------
   task automatic t_reset();
      chk({5'h00, session}, 8'h00);
      chk({7'h00, oe_n}, 8'h01);
      chk({6'h00, master_clear_pin_en, clr_allow}, 8'h00);
   endtask

   task automatic t_cfg();
      for (int i = 0; i < 4; i++) begin
         set_in(i[1:0], 1'b0, 1'b0);
         repeat (2) @(posedge clock);
         #1;
         chk({7'h00, master_clear_pin_en}, {7'h00, i[1] | i[0]});
      end
   endtask

   task automatic t_hv();
      set_in(2'h2, 1'b0, 1'b0);
      i_prog.hv_enter(1'b0);
      wait_sess(3'h6);
      chk({7'h00, clr_allow}, 8'h01);
      i_prog.set_data(1'b1);
      repeat (5) @(posedge clock);
      #1;
      chk({6'h00, rx_dat, rx_clk}, 8'h02);
      i_prog.set_clock(1'b1);
      repeat (5) @(posedge clock);
      #1;
      chk({6'h00, rx_dat, rx_clk}, 8'h03);
      i_prog.set_clock(1'b0);
      set_in(2'h2, 1'b1, 1'b0);
      set_in(2'h2, 1'b1, 1'b1);
      #1;
      chk({6'h00, oe_n, dout}, 8'h00);
      @(posedge clock);
      #1;
      chk({6'h00, oe_n, dout}, 8'h01);
      i_prog.hv_exit();
      wait_sess(3'h0);
      repeat (2) @(posedge clock);
      #1;
      chk({5'h00, oe_n, clr_allow, rx_dat}, 8'h04);
      set_in(2'h2, 1'b0, 1'b0);
   endtask

   task automatic t_hv_refused();
      i_prog.hv_enter(1'b1);
      repeat (12) @(posedge clock);
      #1;
      chk({5'h00, session}, 8'h00);
      i_prog.hv_exit();
   endtask

   task automatic t_lv_good();
      lv_try(2'h2, KEY_DEFAULT, 3'h5);
      chk({7'h00, clr_allow}, 8'h00);
      i_prog.master_clear_pin_release();
      wait_sess(3'h0);
   endtask

   task automatic t_lv_badkey();
      lv_try(2'h2, KEY_DEFAULT ^ 32'h0000_0001, 3'h0);
      lv_try(2'h2, KEY_DEFAULT, 3'h0);
      i_prog.master_clear_pin_release();
   endtask

   task automatic t_lv_disabled();
      lv_try(2'h1, KEY_DEFAULT, 3'h0);
      i_prog.master_clear_pin_release();
      lv_try(2'h2, KEY_DEFAULT, 3'h5);
      i_prog.master_clear_pin_release();
      wait_sess(3'h0);
   endtask

   // reset in mid-session clears the collected key as well
   task automatic t_mid_reset();
      lv_try(2'h2, KEY_DEFAULT, 3'h5);
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      repeat (8) @(posedge clock);
      #1;
      chk({5'h00, session}, 8'h00);
      i_prog.master_clear_pin_release();
   endtask

   // --------------------------------------------------------
   // main sequence and watchdog
   // --------------------------------------------------------
   initial begin
      clock      = 1'b0;
      rst        = 1'b1;
      cfg        = spe_config_t'(2'h0);
      resp_bit   = 1'b0;
      resp_drive = 1'b0;
      n_fail     = 0;
      n_compared = 0;
      repeat (8) @(posedge clock);
      #1;
      t_reset();
      @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      t_cfg();
      t_hv();
      t_hv_refused();
      t_lv_good();
      t_lv_badkey();
      t_lv_disabled();
      t_mid_reset();
      results();
   end

   initial begin
      #200000;
      n_fail++;
      results();
   end

endmodule
